//--- core/tcl_pkg.sv
// constants for the terminal command logic
package tcl_pkg;
  localparam int unsigned NUM_TERM = 7;
  localparam int unsigned CODE_W = 11;
  localparam logic [10:0] LOGIC_OFF_OFS = 11'h3E8;
  localparam logic [10:0] CODE_ALARM_RESET = 11'h008;
  localparam logic [10:0] CODE_TRIP_ON = 11'h3F1;
  localparam logic [10:0] CODE_TRIP_OFF = 11'h009;
  localparam logic [10:0] CODE_LOOP_CANCEL = 11'h014;
  localparam logic [10:0] CODE_DIR_INVERT = 11'h015;
  localparam logic [10:0] CODE_MONITOR = 11'h019;
  localparam logic [10:0] CODE_STOP_ON = 11'h406;
  localparam logic [10:0] CODE_STOP_OFF = 11'h01E;
  localparam logic [10:0] CODE_LOOP_RESET = 11'h021;
  localparam logic [10:0] CODE_INT_HOLD = 11'h022;
  localparam logic [10:0] OUT_ALARM_FUNC = 11'h063;
  localparam logic [10:0] OUT_A_RESET = 11'h000;
  localparam logic [10:0] OUT_B_RESET = 11'h001;
  localparam logic [10:0] OUT_RELAY_RESET = 11'h063;
  localparam logic [19:0] RAMP_MAX = 20'h927C0;
  localparam logic [19:0] RAMP_RESET = 20'h00000;
  localparam logic [9:0] TORQUE_MIN = 10'h014;
  localparam logic [9:0] TORQUE_MAX = 10'h0C8;
  localparam logic [9:0] TORQUE_OFF = 10'h3E7;
  localparam logic [1:0] LOOP_MODE_FWD = 2'h1;
  localparam logic [1:0] LOOP_MODE_REV = 2'h2;
  localparam int unsigned RST_HOLD_MS = 10;
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
  localparam int unsigned RST_CNT_W = 20;
  typedef enum logic [1:0] {TCL_ALM_NONE, TCL_ALM_TRIP, TCL_ALM_STOP} tcl_alarm_t;
endpackage

//--- core/tcl_terminal_cmd.sv
// digital input command decode and drive control state
`timescale 1ns/1ps

// What this block does
// - reset command ON clears alarm output
// - reset command OFF clears alarm display, hold
// - trip input cuts output, shows code, alarms
// - trip condition latched until alarm reset
// - loop cancel selects manual reference
// - manual inversion only on analog command one
// - manual analog direction is setting xor inversion
// - loop direction from mode, inverted by input
// - with loop, inversion acts on loop only
// - monitor inputs reported, never affect drive
// - forced stop ramps down then alarms
// - loop reset clears integral and derivative
// - integral hold freezes integral term
// - ramp times 0 to 6000 s, zero disables
// - torque level 20 to 200, 999 disables
// - output functions default 0, 1, 99
// - each output has normal or inverted logic
// - trip and stop inputs are fail safe
module tcl_terminal_cmd #(
  parameter int unsigned RST_HOLD_CYC = tcl_pkg::RST_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [6:0] term_in,
  input wire logic [6:0][10:0] term_func,
  input wire logic dir_setting,
  input wire logic [1:0] loop_mode,
  input wire logic src_analog_cmd1,
  input wire logic motor_stopped,
  input wire logic ramp_wr,
  input wire logic [2:0] ramp_idx,
  input wire logic [19:0] ramp_data,
  input wire logic torque_wr,
  input wire logic torque_idx,
  input wire logic [9:0] torque_data,
  input wire logic [2:0] out_func_wr,
  input wire logic [10:0] out_func_data,
  input wire logic [2:0] out_src,
  output logic alarm_output,
  output tcl_pkg::tcl_alarm_t alarm_code,
  output logic power_off,
  output logic forced_decel,
  output logic loop_enable,
  output logic loop_terms_reset,
  output logic integral_hold,
  output logic loop_dir_rev,
  output logic manual_dir_rev,
  output logic [6:0] monitor_bits,
  output logic [5:0][19:0] ramp_time,
  output logic [5:0] ramp_disabled,
  output logic [1:0][9:0] torque_level,
  output logic [1:0] torque_limit_off,
  output logic [2:0][10:0] out_func,
  output logic [2:0] out_term
);

  // per terminal hit test, active-ON code or its logic-reversed twin
  function automatic logic [6:0] hit(input logic [6:0][10:0] fn, input logic [6:0] lvl,
                                     input logic [10:0] on_code, input logic [10:0] off_code);
    logic [6:0] h;
    h = '0;
    for (int i = 0; i < 7; i++)
    begin
      h[i] = (fn[i] == on_code && lvl[i]) || (fn[i] == off_code && !lvl[i]);
    end
    return h;
  endfunction

  localparam logic [10:0] OFS = tcl_pkg::LOGIC_OFF_OFS;

  logic [6:0] meta_r;
  logic [6:0] sync_r;
  logic [1:0] sync_vld_r;
  logic [tcl_pkg::RST_CNT_W-1:0] rst_cnt_r;
  logic rst_ok_r;
  logic trip_hold_r;
  logic stop_pend_r;
  logic alarm_output_r;
  tcl_pkg::tcl_alarm_t alarm_code_r;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= 7'h00;
      sync_r <= 7'h00;
      sync_vld_r <= 2'h0;
    end
    else
    begin
      meta_r <= term_in;
      sync_r <= meta_r;
      sync_vld_r <= {sync_vld_r[0], 1'b1};
    end
  end

  // zeroed sync stages would fire every active-off command, so no decode until loaded
  wire [6:0][10:0] func_live = sync_vld_r[1] ? term_func : '0;

  wire reset_cmd = |hit(func_live, sync_r, tcl_pkg::CODE_ALARM_RESET,
                        tcl_pkg::CODE_ALARM_RESET + OFS);
  wire trip_cmd = |hit(func_live, sync_r, tcl_pkg::CODE_TRIP_ON, tcl_pkg::CODE_TRIP_OFF);
  wire stop_cmd = |hit(func_live, sync_r, tcl_pkg::CODE_STOP_ON, tcl_pkg::CODE_STOP_OFF);
  wire cancel_cmd = |hit(func_live, sync_r, tcl_pkg::CODE_LOOP_CANCEL,
                         tcl_pkg::CODE_LOOP_CANCEL + OFS);
  wire inv_cmd = |hit(func_live, sync_r, tcl_pkg::CODE_DIR_INVERT,
                      tcl_pkg::CODE_DIR_INVERT + OFS);
  wire lreset_cmd = |hit(func_live, sync_r, tcl_pkg::CODE_LOOP_RESET,
                         tcl_pkg::CODE_LOOP_RESET + OFS);
  wire ihold_cmd = |hit(func_live, sync_r, tcl_pkg::CODE_INT_HOLD,
                        tcl_pkg::CODE_INT_HOLD + OFS);
  wire [6:0] monitor_nxt = hit(func_live, sync_r, tcl_pkg::CODE_MONITOR,
                               tcl_pkg::CODE_MONITOR + OFS);

  // reset accepted only after the full hold time
  wire rst_cnt_done = rst_cnt_r >= tcl_pkg::RST_CNT_W'(RST_HOLD_CYC);
  wire [tcl_pkg::RST_CNT_W-1:0] rst_cnt_nxt =
    !reset_cmd ? '0 : rst_cnt_done ? rst_cnt_r : rst_cnt_r + 1'b1;
  wire rst_accept = reset_cmd && rst_cnt_done;
  // release on the falling edge of an accepted reset
  wire rst_release = rst_ok_r && !reset_cmd;

  // self held trip, a live trip beats the reset
  wire trip_hold_nxt = trip_cmd || (trip_hold_r && !rst_release);
  wire stop_pend_nxt = stop_cmd || (stop_pend_r && !motor_stopped);
  wire stop_alarm = stop_pend_r && motor_stopped;

  // output dropped while reset held; new events win
  wire alarm_out_nxt = trip_cmd || stop_alarm || (alarm_output_r && !rst_accept);
  tcl_pkg::tcl_alarm_t alarm_code_nxt;
  assign alarm_code_nxt = trip_cmd ? tcl_pkg::TCL_ALM_TRIP :
                          stop_alarm ? tcl_pkg::TCL_ALM_STOP :
                          rst_release ? tcl_pkg::TCL_ALM_NONE : alarm_code_r;

  // loop direction from mode and inversion
  wire loop_rev_nxt = (loop_mode == tcl_pkg::LOOP_MODE_REV) ^ inv_cmd;
  // a configured loop takes the inversion away from manual
  wire loop_cfg = loop_mode == tcl_pkg::LOOP_MODE_FWD || loop_mode == tcl_pkg::LOOP_MODE_REV;
  // only analog sources of command one are inverted
  // manual direction is setting xor inversion
  wire man_rev_nxt = dir_setting ^ (inv_cmd && src_analog_cmd1 && !loop_cfg);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_cnt_r <= '0;
      rst_ok_r <= 1'b0;
      trip_hold_r <= 1'b0;
      stop_pend_r <= 1'b0;
      alarm_output_r <= 1'b0;
      alarm_code_r <= tcl_pkg::TCL_ALM_NONE;
    end
    else
    begin
      rst_cnt_r <= rst_cnt_nxt;
      rst_ok_r <= rst_accept || (rst_ok_r && reset_cmd);
      trip_hold_r <= trip_hold_nxt;
      stop_pend_r <= stop_pend_nxt;
      alarm_output_r <= alarm_out_nxt;
      alarm_code_r <= alarm_code_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alarm_output <= 1'b0;
      alarm_code <= tcl_pkg::TCL_ALM_NONE;
      power_off <= 1'b0;
      forced_decel <= 1'b0;
      loop_enable <= 1'b1;
      loop_terms_reset <= 1'b0;
      integral_hold <= 1'b0;
      loop_dir_rev <= 1'b0;
      manual_dir_rev <= 1'b0;
      monitor_bits <= 7'h00;
    end
    else
    begin
      alarm_output <= alarm_out_nxt;
      alarm_code <= alarm_code_nxt;
      // coast stop while trip is held
      power_off <= trip_hold_nxt;
      forced_decel <= stop_pend_nxt;
      loop_enable <= !cancel_cmd;
      loop_terms_reset <= lreset_cmd;
      integral_hold <= ihold_cmd;
      loop_dir_rev <= loop_rev_nxt;
      manual_dir_rev <= man_rev_nxt;
      monitor_bits <= monitor_nxt;
    end
  end

  // out of range ramp writes are dropped
  wire ramp_ok = ramp_wr && ramp_idx < 3'h6 && ramp_data <= tcl_pkg::RAMP_MAX;
  // torque accepts 20..200 or the off value
  wire torque_ok = torque_wr && ((torque_data >= tcl_pkg::TORQUE_MIN &&
                   torque_data <= tcl_pkg::TORQUE_MAX) || torque_data == tcl_pkg::TORQUE_OFF);
  wire [10:0] out_base = out_func_data >= OFS ? out_func_data - OFS : out_func_data;
  wire out_ok = out_base <= tcl_pkg::OUT_ALARM_FUNC;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ramp_time <= {6{tcl_pkg::RAMP_RESET}};
      ramp_disabled <= 6'h3F;
      torque_level <= {2{tcl_pkg::TORQUE_OFF}};
      torque_limit_off <= 2'h3;
      out_func <= {tcl_pkg::OUT_RELAY_RESET, tcl_pkg::OUT_B_RESET, tcl_pkg::OUT_A_RESET};
    end
    else
    begin
      for (int i = 0; i < 6; i++)
      begin
        if (ramp_ok && ramp_idx == 3'(i))
        begin
          ramp_time[i] <= ramp_data;
          ramp_disabled[i] <= ramp_data == 20'h00000;
        end
      end
      for (int i = 0; i < 2; i++)
      begin
        if (torque_ok && torque_idx == 1'(i))
        begin
          torque_level[i] <= torque_data;
          torque_limit_off[i] <= torque_data == tcl_pkg::TORQUE_OFF;
        end
      end
      for (int i = 0; i < 3; i++)
      begin
        if (out_ok && out_func_wr[i])
        begin
          out_func[i] <= out_func_data;
        end
      end
    end
  end

  // codes from the offset up reverse the logic
  logic [2:0] out_nxt;
  always_comb
  begin
    out_nxt = '0;
    for (int i = 0; i < 3; i++)
    begin
      out_nxt[i] = ((out_func[i] % OFS == tcl_pkg::OUT_ALARM_FUNC) ? alarm_output_r
                    : out_src[i]) ^ (out_func[i] >= OFS);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_term <= 3'h0;
    end
    else
    begin
      out_term <= out_nxt;
    end
  end

  sequence s_trip_seen;
    trip_cmd;
  endsequence
  sequence s_reset_taken;
    rst_accept ##1 !reset_cmd;
  endsequence

  AST_RESET_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_b)
    rst_accept && !trip_cmd && !stop_alarm |=> !alarm_output)
    else $error("alarm output not cleared by reset");
  AST_RELEASE_CODE: assert property (@(posedge core_clk) disable iff (!rst_b)
    rst_release && !trip_cmd && !stop_alarm |=> alarm_code == tcl_pkg::TCL_ALM_NONE)
    else $error("alarm code kept after reset release");
  AST_SHORT_RESET: assert property (@(posedge core_clk) disable iff (!rst_b)
    reset_cmd && !rst_cnt_done && alarm_output |=> alarm_output)
    else $error("short reset pulse accepted");
  AST_TRIP_ACTS: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_trip_seen |=> power_off && alarm_output && alarm_code == tcl_pkg::TCL_ALM_TRIP)
    else $error("trip did not act");
  AST_TRIP_HELD: assert property (@(posedge core_clk) disable iff (!rst_b)
    power_off && !rst_release && !trip_cmd |=> power_off)
    else $error("trip latch dropped without reset");
  AST_CANCEL: assert property (@(posedge core_clk) disable iff (!rst_b)
    cancel_cmd |=> !loop_enable)
    else $error("loop not cancelled");
  AST_MAN_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
    !loop_cfg && src_analog_cmd1 |=> manual_dir_rev == $past(dir_setting ^ inv_cmd))
    else $error("manual direction wrong");
  AST_MAN_LOOP: assert property (@(posedge core_clk) disable iff (!rst_b)
    loop_cfg |=> manual_dir_rev == $past(dir_setting))
    else $error("inversion reached manual direction with loop");
  AST_LOOP_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
    loop_mode == tcl_pkg::LOOP_MODE_FWD |=> loop_dir_rev == $past(inv_cmd))
    else $error("loop direction wrong");
  AST_STOP_ALARM: assert property (@(posedge core_clk) disable iff (!rst_b)
    stop_pend_r && motor_stopped && !trip_cmd |=> alarm_code == tcl_pkg::TCL_ALM_STOP)
    else $error("forced stop alarm missing");
  AST_LOOP_RESET: assert property (@(posedge core_clk) disable iff (!rst_b)
    lreset_cmd ##1 lreset_cmd |-> loop_terms_reset)
    else $error("loop terms reset missing");
  AST_INT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    ihold_cmd |=> integral_hold)
    else $error("integral hold missing");
  AST_TORQUE: assert property (@(posedge core_clk) disable iff (!rst_b)
    torque_wr && torque_data == 10'h0C9 |=> torque_level == $past(torque_level))
    else $error("bad torque level accepted");
  AST_REL_SEQ: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_reset_taken |=> !rst_ok_r)
    else $error("reset release order wrong");

endmodule

//--- tb/tcl_ctrl_model.sv
// external controller model driving the input terminals
`timescale 1ns/1ps
module tcl_ctrl_model (
  input wire logic core_clk,
  output logic [6:0] term_in
);
  // fail-safe trip and stop terminals idle high
  initial term_in = 7'h21;
  task automatic set_term(input int idx, input logic val);
    @(posedge core_clk);
    term_in[idx] <= val;
  endtask
  task automatic pulse_on(input int idx, input int cyc);
    set_term(idx, 1'b1);
    repeat (cyc) @(posedge core_clk);
    term_in[idx] <= 1'b0;
  endtask
endmodule

//--- tb/tcl_terminal_cmd_tb.sv
// self-checking bench for the terminal command logic
`timescale 1ns/1ps
module tcl_terminal_cmd_tb;
  localparam int HOLD = 8;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [6:0] term_in;
  logic [6:0][10:0] term_func = {tcl_pkg::CODE_LOOP_RESET, tcl_pkg::CODE_STOP_OFF,
    tcl_pkg::CODE_MONITOR, tcl_pkg::CODE_DIR_INVERT, tcl_pkg::CODE_LOOP_CANCEL,
    tcl_pkg::CODE_ALARM_RESET, tcl_pkg::CODE_TRIP_OFF};
  logic dir_setting = 1'b0;
  logic [1:0] loop_mode = 2'h0;
  logic src_analog_cmd1 = 1'b1;
  logic motor_stopped = 1'b0;
  logic ramp_wr = 1'b0;
  logic [2:0] ramp_idx = 3'h0;
  logic [19:0] ramp_data = 20'h00000;
  logic torque_wr = 1'b0;
  logic torque_idx = 1'b0;
  logic [9:0] torque_data = 10'h000;
  logic [2:0] out_func_wr = 3'h0;
  logic [10:0] out_func_data = 11'h000;
  logic [2:0] out_src = 3'h0;
  logic alarm_output, power_off, forced_decel, loop_enable, loop_terms_reset;
  logic integral_hold, loop_dir_rev, manual_dir_rev;
  tcl_pkg::tcl_alarm_t alarm_code;
  logic [6:0] monitor_bits;
  logic [5:0][19:0] ramp_time;
  logic [5:0] ramp_disabled;
  logic [1:0][9:0] torque_level;
  logic [1:0] torque_limit_off;
  logic [2:0][10:0] out_func;
  logic [2:0] out_term;
  int errors = 0;
  int checks_done = 0;

  always #5 core_clk = ~core_clk;

  tcl_ctrl_model u_tcl_ctrl_model (.core_clk(core_clk), .term_in(term_in));

  tcl_terminal_cmd #(.RST_HOLD_CYC(HOLD)) u_tcl_terminal_cmd (
    .core_clk(core_clk), .rst_b(rst_b), .term_in(term_in), .term_func(term_func),
    .dir_setting(dir_setting), .loop_mode(loop_mode), .src_analog_cmd1(src_analog_cmd1),
    .motor_stopped(motor_stopped), .ramp_wr(ramp_wr), .ramp_idx(ramp_idx),
    .ramp_data(ramp_data), .torque_wr(torque_wr), .torque_idx(torque_idx),
    .torque_data(torque_data), .out_func_wr(out_func_wr), .out_func_data(out_func_data),
    .out_src(out_src), .alarm_output(alarm_output), .alarm_code(alarm_code),
    .power_off(power_off), .forced_decel(forced_decel), .loop_enable(loop_enable),
    .loop_terms_reset(loop_terms_reset), .integral_hold(integral_hold),
    .loop_dir_rev(loop_dir_rev), .manual_dir_rev(manual_dir_rev),
    .monitor_bits(monitor_bits), .ramp_time(ramp_time), .ramp_disabled(ramp_disabled),
    .torque_level(torque_level), .torque_limit_off(torque_limit_off),
    .out_func(out_func), .out_term(out_term));

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sample one step after the edge so its updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // kind 0 ramp, 1 torque, 2 output function
  task automatic wr_cfg(input int kind, input int idx, input logic [19:0] d);
    @(posedge core_clk);
    ramp_wr <= (kind == 0);
    torque_wr <= (kind == 1);
    out_func_wr <= (kind == 2) ? 3'h1 << idx : 3'h0;
    ramp_idx <= idx[2:0];
    torque_idx <= idx[0];
    ramp_data <= d;
    torque_data <= d[9:0];
    out_func_data <= d[10:0];
    @(posedge core_clk);
    ramp_wr <= 1'b0;
    torque_wr <= 1'b0;
    out_func_wr <= 3'h0;
    wait_cyc(1);
  endtask

  task automatic alarm_clear();
    u_tcl_ctrl_model.set_term(1, 1'b1);
    wait_cyc(HOLD + 4);
    check(alarm_output, 0);
    u_tcl_ctrl_model.set_term(1, 1'b0);
    wait_cyc(4);
    check(alarm_code, tcl_pkg::TCL_ALM_NONE);
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    wrap_up();
  end

  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_cyc(4);
    check(loop_enable, 1);
    check(ramp_disabled, 20'h0003F);
    check(torque_level[1], tcl_pkg::TORQUE_OFF);
    check(torque_limit_off, 20'h00003);
    check(out_func, {tcl_pkg::OUT_RELAY_RESET, tcl_pkg::OUT_B_RESET, tcl_pkg::OUT_A_RESET});
    $display("reset values done");
    u_tcl_ctrl_model.set_term(0, 1'b0);
    wait_cyc(4);
    check({power_off, alarm_output}, 20'h00003);
    check(alarm_code, tcl_pkg::TCL_ALM_TRIP);
    check(out_term[2], 1);
    u_tcl_ctrl_model.set_term(0, 1'b1);
    // short pulse must be refused
    u_tcl_ctrl_model.pulse_on(1, HOLD / 2);
    wait_cyc(6);
    check({power_off, alarm_output}, 20'h00003);
    alarm_clear();
    check(power_off, 0);
    $display("trip and reset done");
    u_tcl_ctrl_model.set_term(2, 1'b1);
    wait_cyc(4);
    check(loop_enable, 0);
    u_tcl_ctrl_model.set_term(2, 1'b0);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge core_clk);
      dir_setting <= i[0];
      loop_mode <= i[3:2];
      u_tcl_ctrl_model.set_term(3, i[1]);
      wait_cyc(4);
      check(manual_dir_rev, (i[3:2] != 0) ? i[0] : i[0] ^ i[1]);
      if (i[3:2] != 0)
        check(loop_dir_rev, i[1] ^ i[3]);
    end
    @(posedge core_clk);
    loop_mode <= 2'h0;
    src_analog_cmd1 <= 1'b0;
    wait_cyc(4);
    // inversion still on, reverse setting must stand alone
    check(manual_dir_rev, 1);
    $display("direction done");
    u_tcl_ctrl_model.set_term(4, 1'b1);
    wait_cyc(4);
    check({monitor_bits, power_off, alarm_output}, 20'h00040);
    u_tcl_ctrl_model.set_term(5, 1'b0);
    wait_cyc(4);
    check({forced_decel, alarm_output}, 20'h00002);
    @(posedge core_clk);
    motor_stopped <= 1'b1;
    wait_cyc(4);
    check({alarm_code, alarm_output}, 20'h00005);
    u_tcl_ctrl_model.set_term(5, 1'b1);
    alarm_clear();
    $display("monitor and stop done");
    u_tcl_ctrl_model.set_term(6, 1'b1);
    wait_cyc(4);
    check({loop_terms_reset, integral_hold}, 20'h00002);
    @(posedge core_clk);
    term_func[6] <= tcl_pkg::CODE_INT_HOLD;
    wait_cyc(4);
    check({loop_terms_reset, integral_hold}, 20'h00001);
    $display("loop terms done");
    wr_cfg(0, 5, tcl_pkg::RAMP_MAX);
    wr_cfg(0, 5, 20'h927C1);
    check(ramp_time[5], tcl_pkg::RAMP_MAX);
    check(ramp_disabled, 20'h0001F);
    wr_cfg(1, 1, 20'h00014);
    wr_cfg(1, 1, 20'h000C9);
    check({torque_limit_off, torque_level[1]}, 20'h00414);
    wr_cfg(1, 1, 20'h003E7);
    check(torque_limit_off, 20'h00003);
    wr_cfg(2, 0, 20'h003ED);
    check(out_func[0], 20'h003ED);
    wait_cyc(2);
    check(out_term[0], 1);
    @(posedge core_clk);
    out_src <= 3'h1;
    wait_cyc(3);
    check(out_term[0], 0);
    $display("configuration done");
    @(posedge core_clk);
    term_func[2] <= tcl_pkg::CODE_LOOP_CANCEL + tcl_pkg::LOGIC_OFF_OFS;
    term_func[4] <= tcl_pkg::CODE_TRIP_ON;
    wait_cyc(3);
    check({loop_enable, power_off}, 20'h00001);
    $display("reversed codes done");
    wrap_up();
  end
endmodule
